/* File: core/vmso_delay_timer.sv */
// Delay timer for the request-driven pre-excitation ready flag
`timescale 1ns/10ps
module vmso_delay_timer #(
  parameter int unsigned CYCLES = 4000000
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic hold,
  // Status
  output logic done
);
  import vmso_pkg::*;
  vmso_tmr_t st;
  vmso_tmr_t next_st;

  // Hold stretches the delay by the time it stays high
  always_comb begin
    next_st = st;
    if (!run) begin
      next_st = '0;
    end else if (!hold && !st.done) begin
      if (st.cnt == 32'(CYCLES - 1)) begin
        next_st.done = 1'b1;
      end else begin
        next_st.cnt = st.cnt + 32'h00000001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;

  a_tmr_idle_clear: assert property (@(posedge aclk)
    disable iff (!aresetn) !run |=> !done && st.cnt == 32'h00000000)
    else $error("delay timer not cleared when idle");
  a_tmr_hold_freeze: assert property (@(posedge aclk)
    disable iff (!aresetn)
    run && hold && !done ##1 run |-> $stable(st.cnt) && !done)
    else $error("delay timer advanced while held");
endmodule

/* File: core/vmso_status_top.sv */
// Drive status flags, terminal routing and AXI4-Lite register slave
//
// Decided for this implementation: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "vmso_consts.svh"
module vmso_status_top #(
  parameter int unsigned PRE_RDY_CYCLES =
    `VMSO_PRE_RDY_MS * (`VMSO_CLK_HZ / 1000)
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire vmso_pkg::vmso_axi_req_t axi_req,
  output vmso_pkg::vmso_axi_rsp_t axi_rsp,
  // Drive state
  input wire vmso_pkg::vmso_drive_t drv,
  // Output terminals
  output logic [`VMSO_N_TERM-1:0] term_pin
);
  import vmso_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vmso_core_t st;
  vmso_core_t next_st;
  vmso_flags_t flags;
  logic main_ok;
  logic shutoff;
  logic live;
  logic zero_speed;
  logic pre_on;
  logic req_pre;
  logic servo;
  logic freq_ok;
  logic tmr_done;
  logic tmr_hold;

  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] data,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Flag evaluation
  // ----------------------------------------------------------------
  always_comb begin
    main_ok = drv.main_power_on && !drv.aux_supply_mode;
    shutoff = drv.fault_trip || drv.output_inhibit_input;
    live = main_ok && !shutoff && !drv.power_fail;
    zero_speed = drv.start_cmd && drv.freq_cmd_zero;
    pre_on = drv.preexcite_active || zero_speed;
    req_pre = pre_on && drv.preexcite_request;
    servo = req_pre && drv.position_mode && drv.servo_lock;
    freq_ok = drv.output_freq >= st.start_freq;
    flags.operation_ready_flag = main_ok && drv.drive_ready
      && !drv.power_fail;
    flags.motor_active_flag = live && ((drv.running && freq_ok
      && !drv.dc_brake && !drv.startup_tuning && !pre_on)
      || servo);
    flags.active_or_start_flag = live && (((drv.running
      || drv.start_cmd || pre_on) && !req_pre) || servo);
    flags.preexcite_ready_flag = live && (((pre_on || drv.running)
      && !req_pre) || (req_pre && tmr_done));
    flags.active_or_command_flag = main_ok && (drv.running
      || drv.start_cmd || pre_on);
  end

  // Tuning in progress with tune_sel at VMSO_TUNE_ONLINE pauses the count so the delay grows by it
  assign tmr_hold = st.tune_sel == `VMSO_TUNE_ONLINE
    && drv.startup_tuning;

  vmso_delay_timer #(
    .CYCLES(PRE_RDY_CYCLES)
  ) u_pre_tmr (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(drv.preexcite_request),
    .hold(tmr_hold),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Terminals
  // ----------------------------------------------------------------
  for (genvar t = 0; t < `VMSO_N_TERM; t++) begin : g_term
    vmso_term_sel u_sel (
      .aclk(aclk),
      .aresetn(aresetn),
      .code(st.term_code[t]),
      .flags(flags),
      .pin(term_pin[t])
    );
  end

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------
  always_comb begin
    logic [5:0] widx;
    logic [5:0] ridx;
    logic [31:0] word;
    logic mapped;
    next_st = st;
    widx = st.awaddr[7:2];
    ridx = axi_req.araddr[7:2];
    word = 32'h00000000;
    mapped = 1'b0;
    axi_rsp.awready = !st.aw_got && !st.bvalid;
    axi_rsp.wready = !st.w_got && !st.bvalid;
    axi_rsp.arready = !st.rvalid;
    axi_rsp.bvalid = st.bvalid;
    axi_rsp.bresp = st.bresp;
    axi_rsp.rvalid = st.rvalid;
    axi_rsp.rdata = st.rdata;
    axi_rsp.rresp = st.rresp;
    if (axi_req.awvalid && axi_rsp.awready) begin
      next_st.aw_got = 1'b1;
      next_st.awaddr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axi_req.wdata;
      next_st.wstrb = axi_req.wstrb;
    end
    if (st.bvalid && axi_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    // Write commits one cycle after both halves are held
    if (st.aw_got && st.w_got) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `VMSO_RESP_OKAY;
      if (st.awaddr == `VMSO_OFS_START_FREQ) begin
        word = merge({16'h0000, st.start_freq}, st.wdata, st.wstrb);
        next_st.start_freq = word[15:0];
      end else if (st.awaddr == `VMSO_OFS_TUNE_SEL) begin
        word = merge({28'h0000000, st.tune_sel}, st.wdata, st.wstrb);
        next_st.tune_sel = word[3:0];
      end else if (st.awaddr == `VMSO_OFS_STATUS) begin
        next_st.bresp = `VMSO_RESP_OKAY;
      end else begin
        for (int t = 0; t < `VMSO_N_TERM; t++) begin
          if (st.awaddr[1:0] == 2'h0
              && widx == `VMSO_IDX_TERM_BASE + 6'(t)) begin
            mapped = 1'b1;
            word = merge({18'h00000, st.term_code[t]}, st.wdata,
              st.wstrb);
            next_st.term_code[t] = word[13:0];
          end
        end
        if (!mapped) begin
          next_st.bresp = `VMSO_RESP_SLVERR;
        end
      end
    end
    if (st.rvalid && axi_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `VMSO_RESP_OKAY;
      next_st.rdata = 32'h00000000;
      // A write committing in this cycle must not mark the read as mapped
      mapped = 1'b0;
      if (axi_req.araddr == `VMSO_OFS_START_FREQ) begin
        next_st.rdata = {16'h0000, st.start_freq};
      end else if (axi_req.araddr == `VMSO_OFS_TUNE_SEL) begin
        next_st.rdata = {28'h0000000, st.tune_sel};
      end else if (axi_req.araddr == `VMSO_OFS_STATUS) begin
        next_st.rdata = {15'h0000, tmr_done, 1'b0, term_pin, 3'h0,
          flags};
      end else begin
        for (int t = 0; t < `VMSO_N_TERM; t++) begin
          if (axi_req.araddr[1:0] == 2'h0
              && ridx == `VMSO_IDX_TERM_BASE + 6'(t)) begin
            mapped = 1'b1;
            next_st.rdata = {18'h00000, st.term_code[t]};
          end
        end
        if (!mapped) begin
          next_st.rresp = `VMSO_RESP_SLVERR;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.start_freq <= `VMSO_START_FREQ_RST;
      st.tune_sel <= `VMSO_TUNE_SEL_RST;
      // Terminals other than 0 start with no function
      st.term_code <= {{(`VMSO_N_TERM - 1){`VMSO_CODE_NONE}},
        `VMSO_CODE_DEF0};
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_wr_both;
    st.aw_got && st.w_got;
  endsequence
  sequence s_bresp_up;
    axi_rsp.bvalid && !axi_rsp.awready && !axi_rsp.wready;
  endsequence

  a_axi_write_resp: assert property (@(posedge aclk)
    disable iff (!aresetn) s_wr_both |=> s_bresp_up)
    else $error("write response missing after both halves");
  a_axi_read_resp: assert property (@(posedge aclk)
    disable iff (!aresetn)
    axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read response missing");
  a_ready_main_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !drv.main_power_on || drv.aux_supply_mode |-> flags == '0)
    else $error("flag on without main circuit power");
  a_ready_pwr_fail: assert property (@(posedge aclk)
    disable iff (!aresetn)
    drv.power_fail |-> !flags.operation_ready_flag)
    else $error("ready on during power failure");
  a_ready_follows: assert property (@(posedge aclk)
    disable iff (!aresetn)
    main_ok && drv.drive_ready && !drv.power_fail
    |-> flags.operation_ready_flag)
    else $error("ready off although the drive can operate");
  a_shutoff_flags_off: assert property (@(posedge aclk)
    disable iff (!aresetn) shutoff |-> !flags.preexcite_ready_flag
    && !flags.motor_active_flag && !flags.active_or_start_flag)
    else $error("flag on during output shutoff");
  a_cmd_follows: assert property (@(posedge aclk)
    disable iff (!aresetn)
    main_ok && drv.start_cmd |-> flags.active_or_command_flag)
    else $error("command flag off with start on");
  a_cmd_idle_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !drv.running && !drv.start_cmd && !pre_on
    |-> !flags.active_or_command_flag)
    else $error("command flag on while stopped");
  a_start_follows: assert property (@(posedge aclk)
    disable iff (!aresetn)
    live && drv.start_cmd && !req_pre |-> flags.active_or_start_flag)
    else $error("start flag off with start on");
  a_motor_freq_gate: assert property (@(posedge aclk)
    disable iff (!aresetn) flags.motor_active_flag && !servo
    |-> drv.output_freq >= st.start_freq && !pre_on)
    else $error("motor flag below starting frequency");
  a_motor_brake_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    (drv.dc_brake || drv.startup_tuning) && !servo
    |-> !flags.motor_active_flag)
    else $error("motor flag on while braking or tuning");
  a_servo_flags_on: assert property (@(posedge aclk)
    disable iff (!aresetn) live && servo
    |-> flags.motor_active_flag && flags.active_or_start_flag)
    else $error("servo lock without running flags");
  a_req_start_off: assert property (@(posedge aclk)
    disable iff (!aresetn)
    req_pre && !servo |-> !flags.active_or_start_flag)
    else $error("start flag on in request pre-excitation");
  a_pre_rdy_on: assert property (@(posedge aclk)
    disable iff (!aresetn)
    live && pre_on && !req_pre |-> flags.preexcite_ready_flag)
    else $error("pre-excite ready off during pre-excitation");
  a_req_ready_delay: assert property (@(posedge aclk)
    disable iff (!aresetn) $rose(drv.preexcite_request)
    |-> !flags.preexcite_ready_flag || !req_pre)
    else $error("pre-excite ready without delay");
  a_req_ready_done: assert property (@(posedge aclk)
    disable iff (!aresetn)
    live && req_pre && tmr_done |-> flags.preexcite_ready_flag)
    else $error("pre-excite ready off after the delay");
  a_term0_default: assert property (@(posedge aclk)
    $rose(aresetn) |-> st.term_code[0] == `VMSO_CODE_DEF0)
    else $error("terminal 0 not defaulted to motor-active");
  a_term_rest_none: assert property (@(posedge aclk)
    $rose(aresetn) |-> st.term_code[`VMSO_N_TERM-1:1]
    == {(`VMSO_N_TERM - 1){`VMSO_CODE_NONE}})
    else $error("spare terminal defaulted to a function");
endmodule

/* File: core/vmso_term_sel.sv */
// One output terminal: function code decode and polarity
`timescale 1ns/10ps
`include "vmso_consts.svh"
module vmso_term_sel (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Selection and flags
  input wire vmso_pkg::vmso_code_t code,
  input wire vmso_pkg::vmso_flags_t flags,
  // Terminal
  output logic pin
);
  import vmso_pkg::*;
  vmso_sel_t st;
  vmso_sel_t next_st;
  logic inv;
  logic hit;
  logic [6:0] base;
  logic level;

  // Codes 100-199 and 300-399 drive the inverted level
  always_comb begin
    inv = 1'b0;
    hit = 1'b1;
    base = 7'h00;
    if (code < 14'd100) begin
      base = 7'(code);
    end else if (code < 14'd200) begin
      base = 7'(code - 14'd100);
      inv = 1'b1;
    end else if (code < 14'd300) begin
      base = 7'(code - 14'd200);
    end else if (code < 14'd400) begin
      base = 7'(code - 14'd300);
      inv = 1'b1;
    end else begin
      hit = 1'b0;
    end
    unique case (base)
      `VMSO_CODE_READY: level = flags.operation_ready_flag;
      `VMSO_CODE_PRE_RDY: level = flags.preexcite_ready_flag;
      `VMSO_CODE_ACTIVE: level = flags.motor_active_flag;
      `VMSO_CODE_ACT_START: level = flags.active_or_start_flag;
      `VMSO_CODE_ACT_CMD: level = flags.active_or_command_flag;
      default: begin
        level = 1'b0;
        hit = 1'b0;
      end
    endcase
    // Unknown functions leave the terminal not conducting
    next_st.pin = hit && (level ^ inv);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pin = st.pin;

  a_sel_one_cycle: assert property (@(posedge aclk)
    disable iff (!aresetn)
    code == 14'd100 |=> pin == !$past(flags.motor_active_flag))
    else $error("negative logic terminal wrong after one cycle");
  a_sel_out_range: assert property (@(posedge aclk)
    disable iff (!aresetn) code >= 14'd400 |=> !pin)
    else $error("out of range code drives terminal");
endmodule

/* File: shared/vmso_consts.svh */
// Offsets, field codes, reset values, clock rate and pre-excitation delay time of the status block
`ifndef VMSO_CONSTS_SVH
`define VMSO_CONSTS_SVH
`define VMSO_CLK_HZ 40000000
`define VMSO_PRE_RDY_MS 100
`define VMSO_N_TERM 7
`define VMSO_OFS_START_FREQ 8'h00
`define VMSO_OFS_TUNE_SEL 8'h04
`define VMSO_IDX_TERM_BASE 6'h02
`define VMSO_OFS_STATUS 8'h24
`define VMSO_START_FREQ_RST 16'h0032
`define VMSO_TUNE_SEL_RST 4'h0
`define VMSO_TUNE_ONLINE 4'h1
`define VMSO_CODE_ACTIVE 7'h00
`define VMSO_CODE_READY 7'h0B
`define VMSO_CODE_PRE_RDY 7'h21
`define VMSO_CODE_ACT_START 7'h2C
`define VMSO_CODE_ACT_CMD 7'h2D
`define VMSO_CODE_NONE 14'h270F
`define VMSO_CODE_DEF0 14'h0000
`define VMSO_RESP_OKAY 2'h0
`define VMSO_RESP_SLVERR 2'h2
`endif

/* File: shared/vmso_pkg.sv */
// Types shared by the status-output block
package vmso_pkg;
  typedef logic [13:0] vmso_code_t;
  typedef struct packed {
    logic main_power_on;
    logic aux_supply_mode;
    logic power_fail;
    logic drive_ready;
    logic running;
    logic start_cmd;
    logic freq_cmd_zero;
    logic fault_trip;
    logic output_inhibit_input;
    logic dc_brake;
    logic startup_tuning;
    logic preexcite_active;
    logic preexcite_request;
    logic position_mode;
    logic servo_lock;
    logic [15:0] output_freq;
  } vmso_drive_t;
  typedef struct packed {
    logic operation_ready_flag;
    logic preexcite_ready_flag;
    logic motor_active_flag;
    logic active_or_start_flag;
    logic active_or_command_flag;
  } vmso_flags_t;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } vmso_axi_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } vmso_axi_rsp_t;
  typedef struct packed {
    logic [31:0] cnt;
    logic done;
  } vmso_tmr_t;
  typedef struct packed {
    logic pin;
  } vmso_sel_t;
  typedef struct packed {
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] start_freq;
    logic [3:0] tune_sel;
    vmso_code_t [6:0] term_code;
  } vmso_core_t;
endpackage

/* File: tb/tb_vector_mode_status_outputs.sv */
// Self-checking bench for the drive status-output block
`timescale 1ns/10ps
`include "vmso_consts.svh"
module tb_vector_mode_status_outputs;
  import vmso_pkg::*;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0] r;
  } vmso_rexp_t;
  // Short pre-excitation delay keeps the run brief
  localparam int unsigned PRE = 20;
  logic aclk;
  logic aresetn;
  vmso_axi_req_t req;
  vmso_axi_rsp_t rsp;
  vmso_drive_t drv;
  logic [6:0] term_pin;
  logic [6:0] ext_seen;
  vmso_rexp_t rq[$];
  logic [1:0] bq[$];
  vmso_code_t codes [7];
  int n_mismatch = 0;
  int checks = 0;
  logic dn;
  logic [15:0] fr [3];
  // Bit order: power, aux, fail, ready, run, start, zero, trip,
  // inhibit, brake, tuning, pre, request, position, servo
  logic [14:0] rows [11] = '{15'h4800, 15'h4E00, 15'h4B00, 15'h4E20,
    15'h4E10, 15'h4280, 15'h4640, 15'h5E00, 15'h6E00, 15'h0800, 15'h4808};
  vmso_code_t sa [7] = '{14'h0000, 14'h000B, 14'h0085, 14'h002C,
    14'h0091, 14'h0064, 14'h002D};
  vmso_code_t sb [7] = '{14'h0000, 14'h006F, 14'h0021, 14'h0090,
    14'h002D, 14'h270F, 14'h0159};

  vmso_status_top #(.PRE_RDY_CYCLES(PRE)) vmso_status_top_i (
    .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
    .drv(drv), .term_pin(term_pin));
  vmso_ext_load vmso_ext_load_i (.aclk(aclk), .term_pin(term_pin),
    .seen(ext_seen));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic vmso_flags_t model(vmso_drive_t d);
    logic off, pre, rp, sv;
    vmso_flags_t f;
    off = d.fault_trip || d.output_inhibit_input || d.power_fail ||
      !d.main_power_on || d.aux_supply_mode;
    pre = d.preexcite_active || (d.start_cmd && d.freq_cmd_zero);
    rp = pre && d.preexcite_request;
    sv = rp && d.position_mode && d.servo_lock;
    f.operation_ready_flag = d.main_power_on && !d.aux_supply_mode &&
      d.drive_ready && !d.power_fail;
    f.preexcite_ready_flag = !off && (rp ? dn : (pre || d.running));
    f.motor_active_flag = !off && (sv || (d.running && !pre &&
      d.output_freq >= `VMSO_START_FREQ_RST && !d.dc_brake &&
      !d.startup_tuning));
    f.active_or_start_flag = !off && (sv || (!rp && (d.running ||
      d.start_cmd || pre)));
    f.active_or_command_flag = d.main_power_on && !d.aux_supply_mode &&
      (d.running || d.start_cmd || pre);
    return f;
  endfunction

  function automatic logic [31:0] st(vmso_flags_t f);
    logic [6:0] p;
    logic v;
    for (int t = 0; t < 7; t++) begin
      case (codes[t] % 14'h0064)
        14'h0000: v = f.motor_active_flag;
        14'h000B: v = f.operation_ready_flag;
        14'h0021: v = f.preexcite_ready_flag;
        14'h002C: v = f.active_or_start_flag;
        default: v = f.active_or_command_flag;
      endcase
      p[t] = (codes[t] < 14'h0190) && (v ^ ((codes[t] / 14'h0064) % 2));
    end
    return {17'h00000, p, 3'h0, f};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    bq.push_back(r);
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && rsp.awready === 1'b1) begin
        aw = 1'b1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready === 1'b1) begin
        w = 1'b1;
        req.wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, m,
    input logic [1:0] r);
    rq.push_back('{d, m, r});
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do @(posedge aclk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge aclk); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
  endtask

  task automatic state(input logic [14:0] row, input logic [15:0] f);
    logic [31:0] x;
    drv <= {row, f};
    repeat (3) @(posedge aclk);
    x = st(model(drv));
    rd(`VMSO_OFS_STATUS, x, 32'h00007FFF, `VMSO_RESP_OKAY);
    // The equipment must see the levels that the status word reports
    chk("term_pin", 32'(ext_seen), 32'(x[14:8]));
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Results are compared in arrival order against the noted expectations
  always @(posedge aclk) begin
    vmso_rexp_t e;
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1) begin
      e = rq.pop_front();
      chk("rdata", rsp.rdata & e.m, e.d);
      chk("rresp", 32'(rsp.rresp), 32'(e.r));
    end
    if (rsp.bvalid === 1'b1 && req.bready === 1'b1) begin
      chk("bresp", 32'(rsp.bresp), 32'(bq.pop_front()));
    end
  end

  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    conclude();
  end

  initial begin
    req = '0;
    drv = '0;
    dn = 1'b0;
    aresetn = 1'b0;
    codes = '{default: `VMSO_CODE_NONE};
    codes[0] = `VMSO_CODE_DEF0;
    void'($urandom(21));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, 32'h00000032, 32'hFFFFFFFF, 2'h0);
    rd(8'h04, 32'h00000000, 32'hFFFFFFFF, 2'h0);
    rd(8'h08, 32'h00000000, 32'hFFFFFFFF, 2'h0);
    rd(8'h0C, 32'h0000270F, 32'hFFFFFFFF, 2'h0);
    rd(8'h20, 32'h0000270F, 32'hFFFFFFFF, 2'h0);
    rd(8'h80, 32'h00000000, 32'hFFFFFFFF, `VMSO_RESP_SLVERR);
    wr(8'hFC, 32'h00000000, `VMSO_RESP_SLVERR);
    wr(`VMSO_OFS_STATUS, 32'hFFFFFFFF, `VMSO_RESP_OKAY);
    state(15'h4800, 16'h0000);
    $display("test register map done");
    for (int s = 0; s < 2; s++) begin
      for (int t = 0; t < 7; t++) begin
        codes[t] = s ? sb[t] : sa[t];
        wr({`VMSO_IDX_TERM_BASE + 6'(t), 2'b00}, 32'(codes[t]), 2'h0);
      end
      for (int r = 0; r < 11; r++) begin
        fr = '{16'h0031, 16'h0032, 16'($urandom_range(0, 255))};
        for (int k = 0; k < 3; k++) begin
          state(rows[r], rows[r][10] ? fr[k] : 16'h0000);
        end
      end
    end
    $display("test flag table done");
    state(15'h480C, 16'h0000);
    repeat (PRE) @(posedge aclk);
    dn = 1'b1;
    state(15'h480C, 16'h0000);
    state(15'h480F, 16'h0000);
    dn = 1'b0;
    state(15'h4808, 16'h0000);
    wr(`VMSO_OFS_TUNE_SEL, 32'(`VMSO_TUNE_ONLINE), 2'h0);
    drv <= {15'h481C, 16'h0000};
    repeat (PRE) @(posedge aclk);
    state(15'h481C, 16'h0000);
    drv <= {15'h480C, 16'h0000};
    repeat (PRE) @(posedge aclk);
    dn = 1'b1;
    state(15'h480C, 16'h0000);
    $display("test pre-excitation delay done");
    conclude();
  end
endmodule

/* File: tb/vmso_ext_load.sv */
// External equipment wired to the drive's output terminals
`timescale 1ns/10ps
module vmso_ext_load (
  // Clock
  input wire logic aclk,
  // Terminals from the drive
  input wire logic [6:0] term_pin,
  // Levels latched by the equipment
  output logic [6:0] seen
);
  // Real equipment filters its inputs; one register stands in for that
  always_ff @(posedge aclk) begin
    seen <= term_pin;
  end
endmodule
